// >>> hw/uhp_defs.svh
/*
 * Offsets, field positions, reset values and timing counts for the
 * host port idle/attach sequencer.
 * Assumes a 20 MHz system clock and a 32-bit Wishbone register bus.
 */
`ifndef UHP_DEFS_SVH
`define UHP_DEFS_SVH

// -----------------------------------------------------------------
// Register offsets (byte addresses)
// -----------------------------------------------------------------
`define UHP_OFF_NEGO     8'h00
`define UHP_OFF_XCVR     8'h04
`define UHP_OFF_STAT     8'h08
`define UHP_OFF_DET      8'h0C

// -----------------------------------------------------------------
// Field positions and codes
// -----------------------------------------------------------------
`define UHP_CANCEL_BIT   7
`define UHP_REQ_LSB      0
`define UHP_REQ_W        4
`define UHP_STATE_LSB    16
`define UHP_REQ_NONE     4'h0
`define UHP_REQ_GO_IDLE  4'h1
`define UHP_REQ_GO_WAIT  4'h2
`define UHP_HS_IDLE      3'h0
`define UHP_HS_WAIT      3'h1
`define UHP_XSEL_FS      2'h1
`define UHP_TSEL_FS      1'h1
`define UHP_OPM_NONDRV   2'h1
`define UHP_OPM_PWRDN    2'h3
`define UHP_SPD_FS       2'h1
`define UHP_LINE_J       2'h1

// -----------------------------------------------------------------
// Timing: figures as printed, then cycle counts at the clock rate
// -----------------------------------------------------------------
`define UHP_CLK_NS       50
`define UHP_CANCEL_REF   6
`define UHP_REF_MHZ      60
`define UHP_CANCEL_CYC   ((`UHP_CANCEL_REF*1000/`UHP_REF_MHZ+`UHP_CLK_NS-1)/`UHP_CLK_NS)
`define UHP_T_FILT_NS    2500
`define UHP_FILT_CYC     ((`UHP_T_FILT_NS+`UHP_CLK_NS-1)/`UHP_CLK_NS)
`define UHP_T_SETTLE_MS  100
`define UHP_SETTLE_CYC   (`UHP_T_SETTLE_MS*1000000/`UHP_CLK_NS+1)
`define UHP_T_DBNC_MS    100
`define UHP_DBNC_CYC     (`UHP_T_DBNC_MS*1000000/`UHP_CLK_NS+1)

`endif

// >>> hw/uhp_pkg.sv
/*
 * Types shared by the host port sequencer.
 * Assumes uhp_defs.svh supplies the numeric codes.
 */
package uhp_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        SQ_IDLE,
        SQ_STOPPED,
        SQ_SETTLE,
        SQ_WAIT_J,
        SQ_DEBOUNCE,
        SQ_ATTACHED
    } uhp_seq_t;

    // Transceiver settings travel together
    typedef struct packed {
        logic [1:0] xcvr_sel;
        logic       term_sel;
        logic [1:0] operation_mode_field;
    } uhp_xcvr_t;

    // Detector enables travel together
    typedef struct packed {
        logic conn;
        logic disc;
        logic wake;
        logic chirp;
    } uhp_det_t;

endpackage : uhp_pkg

// >>> hw/uhp_port_seq.sv
/*
 * Host port sequencer: cancel, go-idle and wait-for-connect (FS attach).
 * Assumes a classic Wishbone master, synchronous line state input and
 * one 20 MHz clock with synchronous active-high reset.
 */
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`include "uhp_defs.svh"

module uhp_port_seq #(
    parameter int SETTLE_CYC = `UHP_SETTLE_CYC, // Supply settle count
    parameter int DBNC_CYC   = `UHP_DBNC_CYC    // Attach debounce count
) (
    input  wire logic             clk_i,      // 20 MHz clock
    input  wire logic             rst_i,      // Sync reset, high
    input  wire logic             wb_cyc_i,   // Bus cycle
    input  wire logic             wb_stb_i,   // Strobe
    input  wire logic             wb_we_i,    // Write enable
    input  wire logic [7:0]       wb_adr_i,   // Byte address
    input  wire logic [3:0]       wb_sel_i,   // Byte lanes
    input  wire logic [31:0]      wb_dat_i,   // Write data
    output logic      [31:0]      wb_dat_o,   // Read data
    output logic                  wb_ack_o,   // Acknowledge
    input  wire logic [1:0]       line_state_i, // Transceiver line state
    output logic                  bus_power_enable_o, // VBUS enable
    output uhp_pkg::uhp_xcvr_t    xcvr_o,     // Transceiver settings
    output logic [1:0]            port_speed_o, // Port speed field
    output logic                  xact_en_o,  // Transactions allowed
    output uhp_pkg::uhp_det_t     det_o       // Detector enables
);

    localparam int CW = 22;

    // The window counter is CW bits wide; a window that does not fit would wrap early
    if (SETTLE_CYC < 1 || SETTLE_CYC >= 2**CW) begin : g_bad_settle
        $error("uhp_port_seq: SETTLE_CYC out of range");
    end
    if (DBNC_CYC < 1 || DBNC_CYC >= 2**CW) begin : g_bad_dbnc
        $error("uhp_port_seq: DBNC_CYC out of range");
    end
    // The stop counter is two bits wide; the line filter shares cnt_ff
    if (`UHP_CANCEL_CYC < 1 || `UHP_CANCEL_CYC > 4) begin : g_bad_cancel
        $error("uhp_port_seq: cancel length does not fit its counter");
    end
    if (`UHP_FILT_CYC < 1 || `UHP_FILT_CYC >= 2**CW) begin : g_bad_filt
        $error("uhp_port_seq: line filter length does not fit its counter");
    end

    // Word decode, shared by read and write paths
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction : hit

    // Request decode: a go request only counts with the cancel bit clear
    function automatic logic req_is(input logic [31:0] dat, input logic [3:0] code);
        req_is = ~dat[`UHP_CANCEL_BIT] &
                 (dat[`UHP_REQ_LSB +: `UHP_REQ_W] == code);
    endfunction : req_is

    // -----------------------------------------------------------------
    // Register state
    // -----------------------------------------------------------------
    logic                   ack_ff, nxt_ack;
    logic [31:0]            dat_ff, nxt_dat;
    logic                   cancel_ff, nxt_cancel;
    logic [1:0]             ccnt_ff, nxt_ccnt;
    logic [3:0]             req_ff, nxt_req;
    logic                   con_flag_ff, nxt_con_flag;
    logic                   wr_go;
    logic                   go_idle;
    logic                   go_wait;

    // -----------------------------------------------------------------
    // Sequencer state
    // -----------------------------------------------------------------
    uhp_pkg::uhp_seq_t      sq_ff, nxt_sq;
    logic [CW-1:0]          cnt_ff, nxt_cnt;
    logic [2:0]             hstate_ff, nxt_hstate;
    logic                   vbus_ff, nxt_vbus;
    uhp_pkg::uhp_xcvr_t     xcvr_ff, nxt_xcvr;
    logic [1:0]             spd_ff, nxt_spd;
    logic                   xact_ff, nxt_xact;
    uhp_pkg::uhp_det_t      det_ff, nxt_det;
    logic                   attach_evt;

    // Write lands on the edge where the master sees ack
    assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff &
                   hit(wb_adr_i, `UHP_OFF_NEGO) & wb_sel_i[0];
    // Go requests are ignored while a cancel is still in progress
    assign go_idle = wr_go & ~cancel_ff & req_is(wb_dat_i, `UHP_REQ_GO_IDLE);
    assign go_wait = wr_go & ~cancel_ff & req_is(wb_dat_i, `UHP_REQ_GO_WAIT);

    // -----------------------------------------------------------------
    // Bus slave and control registers
    // -----------------------------------------------------------------
    // One wait state: ack follows the request, then drops for a cycle
    // Registering ack and read data costs a cycle per access, but keeps
    // every bus output straight off a flip-flop
    always_comb begin
        nxt_ack      = wb_cyc_i & wb_stb_i & ~ack_ff;
        nxt_dat      = 32'h0000_0000;
        nxt_cancel   = cancel_ff;
        nxt_ccnt     = ccnt_ff;
        nxt_req      = req_ff;
        nxt_con_flag = con_flag_ff | attach_evt;
        if (hit(wb_adr_i, `UHP_OFF_NEGO)) begin
            nxt_dat[`UHP_CANCEL_BIT] = cancel_ff;
            nxt_dat[3:0]             = req_ff;
            nxt_dat[18:16]           = hstate_ff;
        end else if (hit(wb_adr_i, `UHP_OFF_XCVR)) begin
            nxt_dat[4:0]   = xcvr_ff;
            nxt_dat[9:8]   = spd_ff;
            nxt_dat[13:12] = line_state_i;
            nxt_dat[16]    = vbus_ff;
        end else if (hit(wb_adr_i, `UHP_OFF_STAT)) begin
            nxt_dat[0] = con_flag_ff;
        end else if (hit(wb_adr_i, `UHP_OFF_DET)) begin
            nxt_dat[3:0] = det_ff;
            nxt_dat[4]   = xact_ff;
        end
        // Cancel write: 0x80 sets the cancel bit, clears the request
        if (wr_go && wb_dat_i[`UHP_CANCEL_BIT]) begin
            nxt_cancel = 1'b1;
            nxt_ccnt   = 2'h0;
            nxt_req    = `UHP_REQ_NONE;
        end else if (cancel_ff) begin
            // Self-clear once the stop has run its fixed length
            if (ccnt_ff == 2'(`UHP_CANCEL_CYC - 1)) begin
                nxt_cancel = 1'b0;
            end else begin
                nxt_ccnt = ccnt_ff + 2'h1;
            end
        end else if (go_idle || go_wait) begin
            nxt_req = wb_dat_i[3:0];
        end
        // Write one to clear; a new attach in the same cycle wins
        if (wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && wb_sel_i[0] &&
            hit(wb_adr_i, `UHP_OFF_STAT) && wb_dat_i[0] && !attach_evt) begin
            nxt_con_flag = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff      <= 1'b0;
            dat_ff      <= 32'h0000_0000;
            cancel_ff   <= 1'b0;
            ccnt_ff     <= 2'h0;
            req_ff      <= `UHP_REQ_NONE;
            con_flag_ff <= 1'b0;
        end else begin
            ack_ff      <= nxt_ack;
            dat_ff      <= nxt_dat;
            cancel_ff   <= nxt_cancel;
            ccnt_ff     <= nxt_ccnt;
            req_ff      <= nxt_req;
            con_flag_ff <= nxt_con_flag;
        end
    end

    // -----------------------------------------------------------------
    // Port sequencer
    // -----------------------------------------------------------------
    // Windows are counted on clk_i; no separate timebase is needed
    // One counter serves settle, filter and debounce, since only one
    // window is ever open; each phase clears it on the way in
    always_comb begin
        nxt_sq     = sq_ff;
        nxt_cnt    = cnt_ff;
        nxt_hstate = hstate_ff;
        nxt_vbus   = vbus_ff;
        nxt_xcvr   = xcvr_ff;
        nxt_spd    = spd_ff;
        nxt_xact   = xact_ff;
        nxt_det    = det_ff;
        attach_evt = 1'b0;
        if (go_idle) begin
            nxt_sq     = uhp_pkg::SQ_IDLE;
            nxt_hstate = `UHP_HS_IDLE;
            nxt_vbus   = 1'b0;
            nxt_xcvr   = {`UHP_XSEL_FS, `UHP_TSEL_FS,
                          `UHP_OPM_NONDRV};
            nxt_xact   = 1'b0;
            nxt_det    = '0;
        end else if (go_wait) begin
            nxt_sq     = uhp_pkg::SQ_SETTLE;
            nxt_cnt    = '0;
            nxt_hstate = `UHP_HS_WAIT;
            nxt_vbus   = 1'b1;
            nxt_xcvr   = {`UHP_XSEL_FS, `UHP_TSEL_FS,
                          `UHP_OPM_PWRDN};
            // Any device, HS capable or not, is taken as FS here
            nxt_spd    = `UHP_SPD_FS;
            nxt_det    = '0;
        end else if (cancel_ff) begin
            // Stop whatever runs; outputs hold until the next request
            // Detector enables stay as they were while stopped, so a cancel
            // is expected to be followed by a go request
            nxt_sq = uhp_pkg::SQ_STOPPED;
        end else begin
            case (sq_ff)
                uhp_pkg::SQ_SETTLE: begin
                    // Let the device supply settle before looking
                    if (cnt_ff == CW'(SETTLE_CYC - 1)) begin
                        nxt_sq       = uhp_pkg::SQ_WAIT_J;
                        nxt_cnt      = '0;
                        nxt_det.conn = 1'b1;
                    end else begin
                        nxt_cnt = cnt_ff + CW'(1);
                    end
                end
                uhp_pkg::SQ_WAIT_J: begin
                    // Any non-J sample restarts the filter
                    if (line_state_i != `UHP_LINE_J) begin
                        nxt_cnt = '0;
                    end else if (cnt_ff == CW'(`UHP_FILT_CYC - 1)) begin
                        nxt_sq       = uhp_pkg::SQ_DEBOUNCE;
                        nxt_cnt      = '0;
                        nxt_det.disc = 1'b1;
                    end else begin
                        nxt_cnt = cnt_ff + CW'(1);
                    end
                end
                uhp_pkg::SQ_DEBOUNCE: begin
                    // The flag rises on the edge that closes the window, and
                    // both detectors drop on that same edge
                    if (line_state_i != `UHP_LINE_J) begin
                        // Disconnect: quietly go back to waiting for J
                        nxt_sq       = uhp_pkg::SQ_WAIT_J;
                        nxt_cnt      = '0;
                        nxt_det.disc = 1'b0;
                    end else if (cnt_ff == CW'(DBNC_CYC - 1)) begin
                        nxt_sq       = uhp_pkg::SQ_ATTACHED;
                        attach_evt   = 1'b1;
                        nxt_det.conn = 1'b0;
                        nxt_det.disc = 1'b0;
                    end else begin
                        nxt_cnt = cnt_ff + CW'(1);
                    end
                end
                default: begin
                    nxt_cnt = cnt_ff;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sq_ff     <= uhp_pkg::SQ_IDLE;
            cnt_ff    <= '0;
            hstate_ff <= `UHP_HS_IDLE;
            vbus_ff   <= 1'b0;
            xcvr_ff   <= {`UHP_XSEL_FS, `UHP_TSEL_FS, `UHP_OPM_NONDRV};
            spd_ff    <= `UHP_SPD_FS;
            xact_ff   <= 1'b0;
            det_ff    <= '0;
        end else begin
            sq_ff     <= nxt_sq;
            cnt_ff    <= nxt_cnt;
            hstate_ff <= nxt_hstate;
            vbus_ff   <= nxt_vbus;
            xcvr_ff   <= nxt_xcvr;
            spd_ff    <= nxt_spd;
            xact_ff   <= nxt_xact;
            det_ff    <= nxt_det;
        end
    end

    // -----------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // -----------------------------------------------------------------
    // Wake, chirp and transaction enables belong to states outside this
    // block; here they only ever fall, which is all go-idle asks of them
    assign wb_ack_o           = ack_ff;
    assign wb_dat_o           = dat_ff;
    assign bus_power_enable_o = vbus_ff;
    assign xcvr_o             = xcvr_ff;
    assign port_speed_o       = spd_ff;
    assign xact_en_o          = xact_ff;
    assign det_o              = det_ff;

endmodule : uhp_port_seq

// >>> bench/uhp_port_seq_checker.sv
/* Assertion checker for the host port sequencer, bound to its top module.
   Assumes one clock, synchronous active-high reset and classic Wishbone. */
`timescale 1ns/100ps
module uhp_port_seq_checker #(
    parameter int SETTLE_CYC = 20, // Supply settle count
    parameter int DBNC_CYC   = 30  // Debounce count
) (
    input wire logic               clk_i,              // Clock
    input wire logic               rst_i,              // Reset
    input wire logic               wb_cyc_i,           // Cycle
    input wire logic               wb_stb_i,           // Strobe
    input wire logic               wb_we_i,            // Write
    input wire logic [7:0]         wb_adr_i,           // Address
    input wire logic [3:0]         wb_sel_i,           // Lanes
    input wire logic [31:0]        wb_dat_i,           // Write data
    input wire logic               wb_ack_o,           // Ack
    input wire logic [1:0]         line_state_i,       // Line state
    input wire logic               bus_power_enable_o, // Bus power
    input wire uhp_pkg::uhp_xcvr_t xcvr_o,             // Transceiver
    input wire logic [1:0]         port_speed_o,       // Speed
    input wire logic               xact_en_o,          // Transactions
    input wire uhp_pkg::uhp_det_t  det_o               // Detectors
);
    localparam int FILT_CYC = 50; // 2.5 us of line state
    logic [1:0] busy_ff, nxt_busy;
    int         wait_ff, nxt_wait, j_ff, nxt_j, dbn_ff, nxt_dbn;
    logic       nego_wr, idle_wr, go_wr;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    // Requests inside the cancel window are dropped, so they are skipped here
    assign nego_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0]
                     & (wb_adr_i[7:2] == 6'h00);
    assign idle_wr = nego_wr & (wb_dat_i[7:0] == 8'h01) & (busy_ff == 2'h0);
    assign go_wr   = nego_wr & (wb_dat_i[7:0] == 8'h02) & (busy_ff == 2'h0);
    always_comb begin
        nxt_busy = (nego_wr && wb_dat_i[7]) ? 2'h3 : busy_ff - {1'b0, busy_ff != 2'h0};
        nxt_wait = go_wr ? 1 : wait_ff + 1;
        nxt_j    = (det_o.conn && line_state_i == 2'h1) ? j_ff + 1 : 0;
        nxt_dbn  = det_o.disc ? dbn_ff + 1 : 0;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_ff <= 2'h0;
            wait_ff <= 0;
            j_ff    <= 0;
            dbn_ff  <= 0;
        end else begin
            busy_ff <= nxt_busy;
            wait_ff <= nxt_wait;
            j_ff    <= nxt_j;
            dbn_ff  <= nxt_dbn;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    idle_power_a: assert property (idle_wr |=> !bus_power_enable_o)
        else $error("bus power on after go-idle");
    idle_outputs_a: assert property (idle_wr |=> xcvr_o == {2'h1, 1'h1, 2'h1}
        && !xact_en_o && det_o == 4'h0) else $error("go-idle outputs wrong");
    wait_entry_a: assert property (go_wr |=> bus_power_enable_o
        && xcvr_o == {2'h1, 1'h1, 2'h3} && port_speed_o == 2'h1 && !det_o.conn)
        else $error("wait-connect entry outputs wrong");
    conn_late_a: assert property ($rose(det_o.conn) |-> wait_ff >= SETTLE_CYC)
        else $error("connect detection enabled too early");
    attach_filt_a: assert property ($rose(det_o.disc) |-> j_ff >= FILT_CYC)
        else $error("attach taken on short J");
    attach_on_a: assert property (det_o.conn && j_ff > FILT_CYC |-> det_o.disc)
        else $error("attach not recognised");
    disc_drop_a: assert property (det_o.disc && line_state_i != 2'h1
        |=> !det_o.disc && det_o.conn) else $error("disconnect not restarting");
    both_off_a: assert property ($fell(det_o.conn) |-> !det_o.disc)
        else $error("detectors not off together");
    dbnc_len_a: assert property ($fell(det_o.conn) && $past(det_o.disc)
        |-> dbn_ff >= DBNC_CYC) else $error("debounce too short");
    cover property (idle_wr);
    cover property (det_o.disc ##1 !det_o.disc && det_o.conn);
    cover property ($fell(det_o.conn) && bus_power_enable_o);
endmodule : uhp_port_seq_checker

bind uhp_port_seq uhp_port_seq_checker #(.SETTLE_CYC(SETTLE_CYC), .DBNC_CYC(DBNC_CYC)) u_chk (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .line_state_i, .bus_power_enable_o, .xcvr_o, .port_speed_o, .xact_en_o, .det_o);

// >>> bench/uhp_dev_model.sv
/* Transceiver line model with an attached full-speed device.
   Assumes the bench plugs it in and may request contact bounce. */
`timescale 1ns/100ps
module uhp_dev_model #(
    parameter logic [7:0] UP_DLY = 8'h05 // Device power-up time
) (
    input  wire logic  clk_i,    // Clock
    input  wire logic  rst_i,    // Reset
    input  wire logic  vbus_i,   // Bus power
    input  wire logic  plug_i,   // Plugged in
    input  wire logic  bounce_i, // Contact bounce
    output logic [1:0] line_o    // Line state
);
    logic [7:0] up_ff, nxt_up;
    // ----------------------------------------
    // Device supply
    // ----------------------------------------
    // Supply ramps only while powered and plugged; a slow part answers late
    always_comb begin
        nxt_up = 8'h00;
        if (vbus_i && plug_i) begin
            nxt_up = (up_ff == 8'hFF) ? up_ff : up_ff + 8'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            up_ff <= 8'h00;
        end else begin
            up_ff <= nxt_up;
        end
    end
    // Pull-downs give SE0 until pull-up; a high-speed part also shows J
    assign line_o = (up_ff > UP_DLY && !bounce_i) ? 2'h1 : 2'h0;
endmodule : uhp_dev_model

// >>> bench/uhp_port_seq_tb.sv
/* Self-checking bench for the host port sequencer and a device model.
   Assumes the checker binds itself; the run takes a few hundred cycles. */
`timescale 1ns/100ps
module uhp_port_seq_tb;
    localparam int SET_C = 20; // Short settle count
    localparam int DBN_C = 30; // Short debounce count
    logic clk, rst, wb_req, wb_we, wb_ack, vbus, plug, bounce, xact;
    logic [7:0]  wb_adr;
    logic [31:0] wb_wd, wb_rd, rd;
    logic [1:0]  line, speed;
    uhp_pkg::uhp_xcvr_t xcvr;
    uhp_pkg::uhp_det_t  det;
    int n_errors, tests_run, c;
    uhp_port_seq #(.SETTLE_CYC(SET_C), .DBNC_CYC(DBN_C)) dut (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_req), .wb_stb_i(wb_req), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd),
        .wb_ack_o(wb_ack), .line_state_i(line), .bus_power_enable_o(vbus), .xcvr_o(xcvr),
        .port_speed_o(speed), .xact_en_o(xact), .det_o(det));
    uhp_dev_model #(.UP_DLY(8'h05)) dev (.clk_i(clk), .rst_i(rst), .vbus_i(vbus),
        .plug_i(plug), .bounce_i(bounce), .line_o(line));
    always #25 clk = ~clk;
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Request held until ack is sampled; bounded so a dead slave cannot hang us
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        wb_req <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_wd  <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rd = wb_rd;
        wb_req <= 1'b0;
        chk("bus answer", 1, n < 20);
    endtask : xfer
    task automatic rchk(input string what, input logic [7:0] adr, input logic [31:0] m,
                        input logic [31:0] exp);
        xfer(1'b0, adr, 32'h0000_0000);
        chk(what, exp, rd & m);
    endtask : rchk
    // Counts settled cycles until a detector enable reaches the level
    task automatic wait_det(input int idx, input logic lvl);
        c = 0;
        while (det[idx] !== lvl && c < 200) begin
            @(negedge clk);
            c++;
        end
    endtask : wait_det
    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rchk("nego reset", 8'h00, 32'h0007_0080, 32'h0000_0000);
        rchk("xcvr reset", 8'h04, 32'h0001_031F, 32'h0000_010D);
        rchk("det reset", 8'h0C, 32'h0000_001F, 32'h0000_0000);
        rchk("unmapped", 8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    endtask : t_reset
    task automatic t_attach;
        xfer(1'b1, 8'h00, 32'h0000_0002);
        @(negedge clk);
        chk("wait power", 1, vbus);
        chk("wait xcvr", 5'h0F, xcvr);
        chk("wait speed", 2'h1, speed);
        wait_det(3, 1'b1);
        chk("settle", 1, c >= SET_C && c < 200);
        wait_det(2, 1'b1);
        chk("attach filter", 1, c >= 50 && c < 200);
        @(posedge clk);
        bounce <= 1'b1;
        @(posedge clk);
        bounce <= 1'b0;
        wait_det(2, 1'b0);
        chk("bounce restart", 1, c < 3 && det.conn === 1'b1);
        rchk("no flag", 8'h08, 32'h0000_0001, 32'h0000_0000);
        wait_det(2, 1'b1);
        chk("attach again", 1, c < 200);
        wait_det(3, 1'b0);
        chk("debounce", 1, c >= DBN_C && c < 200);
        chk("both off", 1'b0, det.disc);
        rchk("flag set", 8'h08, 32'h0000_0001, 32'h0000_0001);
        xfer(1'b1, 8'h08, 32'h0000_0001);
        rchk("flag clear", 8'h08, 32'h0000_0001, 32'h0000_0000);
    endtask : t_attach
    task automatic t_idle;
        rchk("state wait", 8'h00, 32'h0007_0080, 32'h0001_0000);
        xfer(1'b1, 8'h00, 32'h0000_0002);
        wait_det(3, 1'b1);
        chk("rearm", 1, det.conn === 1'b1 && c < 200);
        xfer(1'b1, 8'h00, 32'h0000_0080);
        c = 0;
        do begin
            xfer(1'b0, 8'h00, 32'h0000_0000);
            c++;
        end while (rd[7] !== 1'b0 && c < 5);
        chk("cancel clears", 1'b0, rd[7]);
        xfer(1'b1, 8'h00, 32'h0000_0001);
        @(negedge clk);
        chk("idle power", 1'b0, vbus);
        chk("idle xcvr", 5'h0D, xcvr);
        chk("idle xact", 1'b0, xact);
        chk("idle det", 4'h0, det);
        rchk("state idle", 8'h00, 32'h0007_0000, 32'h0000_0000);
    endtask : t_idle
    initial begin
        clk       = 1'b0;
        rst       = 1'b1;
        wb_req    = 1'b0;
        wb_we     = 1'b0;
        wb_adr    = 8'h00;
        wb_wd     = 32'h0000_0000;
        plug      = 1'b1;
        bounce    = 1'b0;
        n_errors  = 0;
        tests_run = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_attach();
        t_idle();
        end_sim();
    end
    // Watchdog well beyond the few hundred cycles the run needs
    initial begin
        #(50 * 5000);
        n_errors++;
        $display("MISMATCH watchdog expected finish seen timeout");
        end_sim();
    end
endmodule : uhp_port_seq_tb
